// ---- verilog/sdmr_regs.vh ----
// field layout, command codes and reset values of the sdram mode/burst block
// assumes a one-clock design with command pins sampled on the rising edge
`ifndef SDMR_REGS_VH
`define SDMR_REGS_VH

// mode_config field positions
`define SDMR_BL_LSB 0
`define SDMR_BL_MSB 2
`define SDMR_BT_BIT 3
`define SDMR_RL_LSB 4
`define SDMR_RL_MSB 6
`define SDMR_OP_LSB 7
`define SDMR_OP_MSB 8
`define SDMR_WBM_BIT 9
`define SDMR_MODE_W 13

// burst length codes
`define SDMR_BL_1 3'h0
`define SDMR_BL_2 3'h1
`define SDMR_BL_4 3'h2
`define SDMR_BL_8 3'h3
`define SDMR_BL_PAGE 3'h7

// read latency codes
`define SDMR_RL_2 3'h2
`define SDMR_RL_3 3'h3

// command codes {csN, rasN, casN, weN}
`define SDMR_CMD_LOAD 4'h0
`define SDMR_CMD_READ 4'h5
`define SDMR_CMD_WRITE 4'h4
`define SDMR_CMD_TERM 4'h6

// bank-select values for the two mode-register targets
`define SDMR_BA_MAIN 2'h0
`define SDMR_BA_EXT 2'h2

// extended field positions
`define SDMR_PARTIAL_ARRAY_SELF_REFRESH_LSB 0
`define SDMR_PARTIAL_ARRAY_SELF_REFRESH_MSB 2
`define SDMR_TEMP_COMPENSATED_SELF_REFRESH_LSB 3
`define SDMR_TEMP_COMPENSATED_SELF_REFRESH_MSB 4
`define SDMR_DS_LSB 5
`define SDMR_DS_MSB 6

// reset values: main register cleared, extended at its power-up defaults
`define SDMR_MODE_RESET 13'h0000
`define SDMR_EXT_RESET 13'h0018

`endif

// ---- verilog/sdmr_mode_burst.v ----
// mode-register programming and burst column sequencing of a four-bank sdram
// assumes a controller driving command, address and bank pins on the rising
// clock edge; the storage array itself lives elsewhere
//
// Behaviour
// - main mode register written only by load-mode command, held until rewritten
// - load-mode with bank select 10 writes the extended register instead
// - extended defaults: temp-compensated refresh on, full drive, all four banks
// - burst length from mode bits zero to two
// - sequential or interleaved order from mode bit three
// - read latency from mode bits four to six
// - operating mode from bits seven, eight; write-burst mode from bit nine
// - bits ten to twelve reserved, no function; controller loads zero
// - lengths 1,2,4,8 both orders; full page sequential only
// - full page plus burst terminate gives arbitrary lengths
// - burst confined to aligned block of burst length, wrapping
// - block chosen by column bits above the offset bits
// - low column bits choose start within block
// - full page steps by one, wraps to column zero, continues
// - sequential adds index modulo length; interleaved xors index
// - write-burst bit set makes every write a single access
// - read data driven one edge before, valid at, command edge plus latency
`timescale 1ns/1ps
`include "sdmr_regs.vh"

module sdmr_mode_burst #(
   parameter COL_W = 8
) (
   input wire clk,
   input wire rst,
   input wire csN,
   input wire rasN,
   input wire casN,
   input wire weN,
   input wire [11:0] addr,
   input wire [1:0] bankSel,
   output reg [12:0] modeConfig,
   output reg [12:0] extendedModeConfig,
   output wire [2:0] burstLengthField,
   output wire burstTypeBit,
   output wire [2:0] readLatencyField,
   output wire [1:0] opMode,
   output wire writeBurstModeBit,
   output wire [2:0] partialArraySelfRefresh,
   output wire [1:0] tempCompensatedSelfRefresh,
   output wire [1:0] driveStrength,
   output reg accessValid,
   output reg accessWrite,
   output reg [1:0] accessBank,
   output reg [COL_W-1:0] accessCol,
   output reg readDrive,
   output reg readValid,
   output reg [COL_W-1:0] readCol
);

   wire [3:0] cmd = {csN, rasN, casN, weN};
   // every other pin pattern (deselect, nop, row commands) is ignored here
   reg isLoad;
   reg isRead;
   reg isWrite;
   reg isTerm;
   always @* begin
      isLoad = 1'b0;
      isRead = 1'b0;
      isWrite = 1'b0;
      isTerm = 1'b0;
      case (cmd)
         `SDMR_CMD_LOAD: begin
            isLoad = 1'b1;
         end
         `SDMR_CMD_READ: begin
            isRead = 1'b1;
         end
         `SDMR_CMD_WRITE: begin
            isWrite = 1'b1;
         end
         `SDMR_CMD_TERM: begin
            isTerm = 1'b1;
         end
         default: begin
            isLoad = 1'b0;
         end
      endcase
   end

   // load target from bank select; 01 and 11 select nothing
   reg loadMain;
   reg loadExt;
   always @* begin
      loadMain = 1'b0;
      loadExt = 1'b0;
      if (isLoad) begin
         case (bankSel)
            `SDMR_BA_MAIN: begin
               loadMain = 1'b1;
            end
            `SDMR_BA_EXT: begin
               loadExt = 1'b1;
            end
            default: begin
               loadMain = 1'b0;
            end
         endcase
      end
   end

   // field views; reserved bits 10..12 feed nothing
   assign burstLengthField = modeConfig[`SDMR_BL_MSB:`SDMR_BL_LSB];
   assign burstTypeBit = modeConfig[`SDMR_BT_BIT];
   assign readLatencyField = modeConfig[`SDMR_RL_MSB:`SDMR_RL_LSB];
   assign opMode = modeConfig[`SDMR_OP_MSB:`SDMR_OP_LSB];
   assign writeBurstModeBit = modeConfig[`SDMR_WBM_BIT];
   assign partialArraySelfRefresh = extendedModeConfig[`SDMR_PARTIAL_ARRAY_SELF_REFRESH_MSB:`SDMR_PARTIAL_ARRAY_SELF_REFRESH_LSB];
   assign tempCompensatedSelfRefresh = extendedModeConfig[`SDMR_TEMP_COMPENSATED_SELF_REFRESH_MSB:`SDMR_TEMP_COMPENSATED_SELF_REFRESH_LSB];
   assign driveStrength = extendedModeConfig[`SDMR_DS_MSB:`SDMR_DS_LSB];

   // mode registers; pin a12 does not exist, so bit 12 always loads zero
   always @(posedge clk) begin
      if (rst) begin
         modeConfig <= `SDMR_MODE_RESET;
         extendedModeConfig <= `SDMR_EXT_RESET;
      end else begin
         if (loadMain) begin
            modeConfig <= {1'b0, addr};
         end
         if (loadExt) begin
            extendedModeConfig <= {1'b0, addr};
         end
      end
   end

   // burst length decode into an offset mask; reserved codes act as length one
   reg [COL_W-1:0] lenMask;
   reg fullPage;
   always @* begin
      lenMask = {COL_W{1'b0}};
      fullPage = 1'b0;
      case (burstLengthField)
         `SDMR_BL_1: begin
            lenMask = {COL_W{1'b0}};
         end
         `SDMR_BL_2: begin
            lenMask = {{(COL_W-1){1'b0}}, 1'b1};
         end
         `SDMR_BL_4: begin
            lenMask = {{(COL_W-2){1'b0}}, 2'h3};
         end
         `SDMR_BL_8: begin
            lenMask = {{(COL_W-3){1'b0}}, 3'h7};
         end
         `SDMR_BL_PAGE: begin
            lenMask = {COL_W{1'b1}};
            fullPage = 1'b1;
         end
         default: begin
            lenMask = {COL_W{1'b0}};
         end
      endcase
   end

   // burst state; one column per clock, so the array behind must keep pace
   localparam ST_IDLE = 1'b0;
   localparam ST_BURST = 1'b1;
   reg state;
   reg [COL_W-1:0] startCol;
   reg [COL_W-1:0] mask;
   reg [COL_W-1:0] idx;
   reg interleave;
   reg pageMode;
   reg curWrite;
   reg [1:0] curBank;

   // next column from start, index and mask
   function [COL_W-1:0] colOf;
      input [COL_W-1:0] st;
      input [COL_W-1:0] ix;
      input [COL_W-1:0] mk;
      input il;
      reg [COL_W-1:0] off;
      begin
         if (il) begin
            off = (st ^ ix) & mk;
         end else begin
            off = (st + ix) & mk;
         end
         colOf = (st & ~mk) | off;
      end
   endfunction

   // a write with the write-burst bit set is a single access
   wire singleWrite = isWrite & writeBurstModeBit;
   wire [COL_W-1:0] cmdMask = singleWrite ? {COL_W{1'b0}} : lenMask;
   wire cmdPage = fullPage & ~singleWrite;
   // interleaved full page is unsupported; it runs sequential
   wire cmdInterleave = burstTypeBit & ~cmdPage;
   wire [COL_W-1:0] cmdCol = addr[COL_W-1:0];
   wire [COL_W-1:0] nextIdx = idx + {{(COL_W-1){1'b0}}, 1'b1};
   // a fixed burst ends when the index wraps inside the offset mask
   wire lastBeat = (nextIdx & mask) == {COL_W{1'b0}};

   always @(posedge clk) begin
      if (rst) begin
         state <= ST_IDLE;
         startCol <= {COL_W{1'b0}};
         mask <= {COL_W{1'b0}};
         idx <= {COL_W{1'b0}};
         interleave <= 1'b0;
         pageMode <= 1'b0;
         curWrite <= 1'b0;
         curBank <= 2'h0;
         accessValid <= 1'b0;
         accessWrite <= 1'b0;
         accessBank <= 2'h0;
         accessCol <= {COL_W{1'b0}};
      end else if (isRead | isWrite) begin
         // a new column command cuts any running burst short
         startCol <= cmdCol;
         mask <= cmdMask;
         interleave <= cmdInterleave;
         pageMode <= cmdPage;
         curWrite <= isWrite;
         curBank <= bankSel;
         idx <= {{(COL_W-1){1'b0}}, 1'b1};
         accessValid <= 1'b1;
         accessWrite <= isWrite;
         accessBank <= bankSel;
         accessCol <= cmdCol;
         if (cmdMask == {COL_W{1'b0}}) begin
            state <= ST_IDLE;
         end else begin
            state <= ST_BURST;
         end
      end else if (isTerm) begin
         state <= ST_IDLE;
         accessValid <= 1'b0;
      end else begin
         case (state)
            ST_BURST: begin
               accessValid <= 1'b1;
               accessWrite <= curWrite;
               accessBank <= curBank;
               accessCol <= colOf(startCol, idx, mask, interleave);
               idx <= nextIdx;
               // a page burst never ends by itself, it wraps past the top column
               if (lastBeat & ~pageMode) begin
                  state <= ST_IDLE;
               end
            end
            default: begin
               accessValid <= 1'b0;
            end
         endcase
      end
   end

   // read latency pipeline; stage k is high k+1 edges after the command edge
   // only column timing is modelled, the data path lives with the array
   reg [1:0] rdPipe;
   reg [COL_W-1:0] rdCol0;
   reg [COL_W-1:0] rdCol1;
   // reserved latency codes are run as three clocks
   reg lat2;
   always @* begin
      case (readLatencyField)
         `SDMR_RL_2: begin
            lat2 = 1'b1;
         end
         default: begin
            lat2 = 1'b0;
         end
      endcase
   end
   // a read access appears one edge after its edge, so stage 0 is edge n+1
   wire rdNow = accessValid & ~accessWrite;

   // drive from edge n+m-1, valid from edge n+m
   reg next_readDrive;
   reg next_readValid;
   reg [COL_W-1:0] next_readCol;
   always @* begin
      if (lat2) begin
         next_readDrive = rdNow;
         next_readValid = rdPipe[0];
         next_readCol = rdCol0;
      end else begin
         next_readDrive = rdPipe[0];
         next_readValid = rdPipe[1];
         next_readCol = rdCol1;
      end
   end

   always @(posedge clk) begin
      if (rst) begin
         rdPipe <= 2'h0;
         rdCol0 <= {COL_W{1'b0}};
         rdCol1 <= {COL_W{1'b0}};
         readDrive <= 1'b0;
         readValid <= 1'b0;
         readCol <= {COL_W{1'b0}};
      end else begin
         rdPipe <= {rdPipe[0], rdNow};
         rdCol0 <= accessCol;
         rdCol1 <= rdCol0;
         readDrive <= next_readDrive;
         readValid <= next_readValid;
         readCol <= next_readCol;
      end
   end

endmodule

// ---- bench/sdmr_mode_burst_props.sv ----
// port checks for the mode/burst block
// assumes command pins change just after the rising edge
`timescale 1ns/1ps
`include "sdmr_regs.vh"
module sdmr_mode_burst_props #(
   parameter COL_W = 8
) (
   input wire clk,
   input wire rst,
   input wire csN,
   input wire rasN,
   input wire casN,
   input wire weN,
   input wire [11:0] addr,
   input wire [1:0] bankSel,
   input wire [12:0] modeConfig,
   input wire [12:0] extendedModeConfig,
   input wire [2:0] burstLengthField,
   input wire [2:0] readLatencyField,
   input wire writeBurstModeBit,
   input wire accessValid,
   input wire accessWrite,
   input wire [COL_W-1:0] accessCol,
   input wire readDrive,
   input wire readValid,
   input wire [COL_W-1:0] readCol
);
   wire [3:0] cmd = {csN, rasN, casN, weN};
   wire rw = cmd == `SDMR_CMD_READ || cmd == `SDMR_CMD_WRITE;
   wire ldMain = cmd == `SDMR_CMD_LOAD && bankSel == `SDMR_BA_MAIN;
   default clocking dc @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_rd_beat;
      accessValid && !accessWrite && readLatencyField == `SDMR_RL_2;
   endsequence
   sequence s_wr_single;
      cmd == `SDMR_CMD_WRITE && writeBurstModeBit;
   endsequence
   sequence s_rd_beat3;
      accessValid && !accessWrite && readLatencyField != `SDMR_RL_2;
   endsequence
   chk_main_load: assert property (
      ldMain |=> modeConfig == {1'b0, $past(addr)}) else $error("main load wrong");
   chk_main_hold: assert property (
      !ldMain |=> $stable(modeConfig)) else $error("main changed");
   chk_ext_load: assert property (
      cmd == `SDMR_CMD_LOAD && bankSel == `SDMR_BA_EXT
      |=> extendedModeConfig == {1'b0, $past(addr)}) else $error("ext load wrong");
   chk_first_beat: assert property (
      rw |=> accessValid && accessCol == $past(addr[COL_W-1:0]) && accessWrite == !$past(weN))
      else $error("first beat wrong");
   chk_term_stop: assert property (
      cmd == `SDMR_CMD_TERM |=> !accessValid) else $error("no stop");
   chk_write_single: assert property (
      s_wr_single ##1 !rw |=> !accessValid) else $error("write not single");
   chk_page_step: assert property (
      accessValid && burstLengthField == `SDMR_BL_PAGE && !rw && cmd != `SDMR_CMD_TERM
      && !(accessWrite && writeBurstModeBit)
      |=> accessValid && accessCol == COL_W'($past(accessCol) + 1'b1)) else $error("page step");
   chk_lat_two: assert property (
      s_rd_beat |=> readDrive ##1 readValid && readCol == $past(accessCol, 2))
      else $error("latency two");
   chk_lat_three: assert property (
      s_rd_beat3 |-> ##2 readDrive ##1 readValid && readCol == $past(accessCol, 3))
      else $error("latency three");
endmodule
bind sdmr_mode_burst sdmr_mode_burst_props #(.COL_W(COL_W)) i_props (.clk(clk), .rst(rst),
   .csN(csN), .rasN(rasN), .casN(casN), .weN(weN), .addr(addr), .bankSel(bankSel),
   .modeConfig(modeConfig), .extendedModeConfig(extendedModeConfig),
   .burstLengthField(burstLengthField), .readLatencyField(readLatencyField),
   .writeBurstModeBit(writeBurstModeBit), .accessValid(accessValid), .accessWrite(accessWrite),
   .accessCol(accessCol), .readDrive(readDrive), .readValid(readValid), .readCol(readCol));

// ---- bench/sdmr_ctrl_model.sv ----
// controller model driving the command, address and bank pins
// assumes the bench raises go just after a rising edge
`timescale 1ns/1ps
`include "sdmr_regs.vh"
module sdmr_ctrl_model (
   input wire clk,
   input wire go,
   input wire [3:0] cmdIn,
   input wire [11:0] addrIn,
   input wire [1:0] bankIn,
   output wire csN,
   output wire rasN,
   output wire casN,
   output wire weN,
   output wire [11:0] addr,
   output wire [1:0] bankSel
);
   reg [11:0] idleAddr = 12'h000;
   // loads pass whenever go is high, with reserved and op-mode bits cleared
   wire [11:0] ldVal = cmdIn == `SDMR_CMD_LOAD ? addrIn & 12'h27f : addrIn;
   // the bench only loads after the last burst has drained
   assign {csN, rasN, casN, weN} = go ? cmdIn : 4'hf;
   // idle address pins keep toggling so a stale address never looks valid
   assign addr = go ? ldVal : idleAddr;
   assign bankSel = go ? bankIn : ~bankIn;
   always @(posedge clk) begin
      idleAddr <= ~addr;
   end
endmodule

// ---- bench/test_sdram_mode_register_burst_order.sv ----
// self-checking bench: random modes, start columns and banks
// assumes the controller model, the bound checker and 8-bit columns
`timescale 1ns/1ps
`include "sdmr_regs.vh"
module test_sdram_mode_register_burst_order;
   reg clk = 1'b0;
   reg rst = 1'b1;
   reg go = 1'b0;
   reg [3:0] cmdIn = 4'hf;
   reg [11:0] addrIn = 12'h000;
   reg [1:0] bankIn = 2'h0;
   reg [31:0] seed = 32'h4b1fe945;
   reg [2:0] blc;
   reg [11:0] v;
   reg [7:0] st;
   integer nMismatch = 0;
   integer samplesChecked = 0;
   integer i;
   integer j;
   integer k;
   integer len;
   wire csN, rasN, casN, weN, accessValid;
   wire [11:0] addr;
   wire [1:0] bankSel;
   wire [12:0] modeConfig;
   wire [12:0] extendedModeConfig;
   wire [7:0] accessCol;
   wire accessWrite;
   wire burstTypeBit;
   wire [1:0] accessBank;
   wire [1:0] opMode;
   wire [2:0] partialArraySelfRefresh;
   wire [1:0] tempCompensatedSelfRefresh;
   wire [1:0] driveStrength;
   always #4 clk = ~clk;
   sdmr_ctrl_model i_ctrl (.clk(clk), .go(go), .cmdIn(cmdIn), .addrIn(addrIn), .bankIn(bankIn),
      .csN(csN), .rasN(rasN), .casN(casN), .weN(weN), .addr(addr), .bankSel(bankSel));
   sdmr_mode_burst #(.COL_W(8)) i_dut (.clk(clk), .rst(rst), .csN(csN), .rasN(rasN),
      .casN(casN), .weN(weN), .addr(addr), .bankSel(bankSel), .modeConfig(modeConfig),
      .extendedModeConfig(extendedModeConfig), .burstLengthField(), .burstTypeBit(burstTypeBit),
      .readLatencyField(), .opMode(opMode), .writeBurstModeBit(),
      .partialArraySelfRefresh(partialArraySelfRefresh),
      .tempCompensatedSelfRefresh(tempCompensatedSelfRefresh),
      .driveStrength(driveStrength), .accessValid(accessValid),
      .accessWrite(accessWrite), .accessBank(accessBank), .accessCol(accessCol), .readDrive(),
      .readValid(),
      .readCol());
   function [31:0] xs(input [31:0] s);
      xs = s ^ (s << 13);
      xs = xs ^ (xs >> 17);
      xs = xs ^ (xs << 5);
   endfunction
   function [7:0] expCol(input [7:0] s, input [7:0] kk, input [7:0] mk, input il);
      expCol = (s & ~mk) | ((il ? s ^ kk : s + kk) & mk);
   endfunction
   task check(input string name, input [15:0] exp, input [15:0] seen);
      samplesChecked = samplesChecked + 1;
      if (seen !== exp) begin
         nMismatch = nMismatch + 1;
         $display("[FAIL] %0s expected %h seen %h", name, exp, seen);
      end
   endtask
   task issue(input [3:0] c, input [11:0] a, input [1:0] b);
      @(posedge clk);
      go <= 1'b1;
      cmdIn <= c;
      addrIn <= a;
      bankIn <= b;
      @(posedge clk);
      go <= 1'b0;
   endtask
   task printVerdict;
      $display("checks %0d mismatches %0d", samplesChecked, nMismatch);
      if (nMismatch == 0 && samplesChecked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      nMismatch = nMismatch + 1;
      printVerdict;
   end
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      #1;
      check("ext reset", `SDMR_EXT_RESET, extendedModeConfig);
      check("banks", 3'h0, partialArraySelfRefresh);
      check("temp_compensated_self_refresh", 2'h3, tempCompensatedSelfRefresh);
      check("drive", 2'h0, driveStrength);
      for (i = 0; i < 20; i = i + 1) begin
         seed = xs(seed);
         blc = (i % 10 < 8) ? i % 4 : `SDMR_BL_PAGE;
         // mode bits: write-burst, latency, type, length; reserved stay zero
         v = {2'h0, seed[1], 2'h0, seed[0] ? `SDMR_RL_3 : `SDMR_RL_2, seed[2], blc};
         issue(`SDMR_CMD_LOAD, v, `SDMR_BA_MAIN);
         #1;
         check("mode", {1'b0, v}, modeConfig);
         check("type", v[3], burstTypeBit);
         check("op", 2'h0, opMode);
         // a page start near the top forces the wrap to column zero
         st = blc == `SDMR_BL_PAGE ? 8'hfa : seed[15:8];
         for (j = 0; j < 2; j = j + 1) begin
            len = (j == 1 && v[9]) ? 1 : (blc == `SDMR_BL_PAGE ? 12 : 1 << blc);
            issue(j ? `SDMR_CMD_WRITE : `SDMR_CMD_READ, {seed[27:24], st}, seed[29:28]);
            for (k = 0; k < len; k = k + 1) begin
               #1;
               check("col", blc == `SDMR_BL_PAGE ? expCol(st, k, 8'hff, 1'b0) :
                  expCol(st, k, (1 << blc) - 1, v[3]), accessCol);
               check("dir", j, accessWrite);
               check("bank", seed[29:28], accessBank);
               @(posedge clk);
            end
            if (blc == `SDMR_BL_PAGE)
               issue(`SDMR_CMD_TERM, seed[11:0], 2'h0);
            #1;
            check("end", 1'b0, accessValid);
            repeat (4) @(posedge clk);
         end
         $display("mode test %0d done", i);
      end
      issue(`SDMR_CMD_LOAD, 12'h065, `SDMR_BA_EXT);
      issue(`SDMR_CMD_LOAD, 12'h0aa, 2'h1);
      #1;
      check("ext", 13'h0065, extendedModeConfig);
      check("main kept", {1'b0, v}, modeConfig);
      $display("extended test done");
      printVerdict;
   end
endmodule
